// File: inc/pmaf_pkg.sv
// Functional notes
// RULE_01: The Port 1 low mode register sits at AEh, resets to 00h and holds pins 0 to 3, pin n in bits 2n+1 and 2n.
// RULE_02: The Port 1 high mode register sits at AFh, resets to 00h and holds pins 4 to 7, pin 7 on top.
// RULE_03: Each two-bit mode code means 00 quasi-bidirectional, 01 push-pull, 10 open-drain and 11 input only.
// RULE_04: The Port 3 data latch sits at B0h, resets to FFh and serves pins 0 to 7 as general-purpose I/O.
// RULE_05: A Port 3 pin works in its alternate function only while its latch bit is one, and software sets that bit first.
// RULE_06: Port 3 pin 5 counts timer one on every high-to-low transition.
// RULE_07: Port 3 pin 4 counts timer zero on every high-to-low transition.
// RULE_08: Port 3 pin 3 requests external interrupt one on a falling edge or low level when that interrupt is enabled.
// RULE_09: Port 3 pin 2 requests external interrupt zero on a falling edge or low level when that interrupt is enabled.
// RULE_10: Port 3 pin 1 carries serial zero transmit data in modes 1 to 3 and the shift clock in mode 0.
// RULE_11: Port 3 pin 0 takes serial zero receive data in modes 1 to 3 and is the two-way data line in mode 0.
// RULE_12: Port 3 pin 6 is shared by the serial peripheral clock, the two-wire clock and a clock output, chosen by a select register.
// RULE_13: Port 3 pins use the same mode fields as Port 1, in a low register at B3h and a high one at B4h, both reset to 00h.
// RULE_14: A port data read returns the pin level for pins in input mode and the latch otherwise, and writes always load the latch.
package pmaf_pkg;
    localparam logic [7:0] PMAF_ADDR_P1_LATCH = 8'h90;
    localparam logic [7:0] PMAF_ADDR_P1_MODE_LO = 8'hAE;
    localparam logic [7:0] PMAF_ADDR_P1_MODE_HI = 8'hAF;
    localparam logic [7:0] PMAF_ADDR_P3_LATCH = 8'hB0;
    localparam logic [7:0] PMAF_ADDR_P3_MODE_LO = 8'hB3;
    localparam logic [7:0] PMAF_ADDR_P3_MODE_HI = 8'hB4;
    localparam logic [7:0] PMAF_ADDR_PIN_SEL = 8'hF2;
    localparam logic [7:0] PMAF_RST_MODE = 8'h00;
    localparam logic [7:0] PMAF_RST_LATCH = 8'hFF;
    localparam logic [7:0] PMAF_RST_PIN_SEL = 8'h00;
    localparam logic [7:0] PMAF_RD_UNMAPPED = 8'h00;
    localparam logic [7:0] PMAF_PIN_SEL_MASK = 8'h03;
    localparam int unsigned PMAF_PIN_TXD = 1;
    localparam int unsigned PMAF_PIN_RXD = 0;
    localparam int unsigned PMAF_PIN_IRQ0 = 2;
    localparam int unsigned PMAF_PIN_IRQ1 = 3;
    localparam int unsigned PMAF_PIN_TMR0 = 4;
    localparam int unsigned PMAF_PIN_TMR1 = 5;
    localparam int unsigned PMAF_PIN_CLK = 6;
    localparam logic [1:0] PMAF_SER_MODE0 = 2'h0;

    typedef enum logic [1:0] {
        PMAF_MODE_QUASI = 2'b00,
        PMAF_MODE_PUSH_PULL = 2'b01,
        PMAF_MODE_OPEN_DRAIN = 2'b10,
        PMAF_MODE_INPUT = 2'b11
    } pmaf_mode_t;

    typedef enum logic [1:0] {
        PMAF_CLK_SERIAL = 2'b00,
        PMAF_CLK_TWO_WIRE = 2'b01,
        PMAF_CLK_SOURCE = 2'b10,
        PMAF_CLK_NONE = 2'b11
    } pmaf_clk_sel_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pmaf_sfr_req_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pmaf_pins_t;
endpackage

// File: rtl/pmaf_pin_cell.sv
`timescale 1ns/100ps
`default_nettype none
module pmaf_pin_cell
    import pmaf_pkg::*;
(
    input wire pmaf_mode_t mode,
    input wire logic value,
    output logic drv_out,
    output logic drv_oe
);
    always_comb begin
        drv_out = value;
        drv_oe = 1'b0;
        case (mode) // RULE_03
            // quasi mode only pulls low; the weak high comes from the pad pull-up
            PMAF_MODE_QUASI: begin
                drv_oe = ~value;
            end
            PMAF_MODE_PUSH_PULL: begin
                drv_oe = 1'b1;
            end
            PMAF_MODE_OPEN_DRAIN: begin
                drv_oe = ~value;
            end
            default: begin
                drv_oe = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: rtl/pmaf_port.sv
`timescale 1ns/100ps
`default_nettype none
module pmaf_port
    import pmaf_pkg::*;
(
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire pmaf_sfr_req_t SFR_REQ,
    output logic [7:0] SFR_RDATA,
    input wire logic [7:0] P1_IN,
    output pmaf_pins_t P1_PINS,
    input wire logic [7:0] P3_IN,
    output pmaf_pins_t P3_PINS,
    input wire logic SER0_ACTIVE,
    input wire logic [1:0] SER0_MODE,
    input wire logic SER0_TXD,
    input wire logic SER0_SHIFT_CLK,
    input wire logic SER0_M0_DOUT,
    input wire logic SER0_M0_DRIVE,
    input wire logic CLK_SHARE_ACTIVE,
    input wire logic SPI_SCK,
    input wire logic TWI_SCL,
    input wire logic CLKS_OUT,
    input wire logic EXT_IRQ0_EN,
    input wire logic EXT_IRQ1_EN,
    input wire logic EXT_IRQ0_EDGE,
    input wire logic EXT_IRQ1_EDGE,
    output logic TMR0_COUNT,
    output logic TMR1_COUNT,
    output logic EXT_IRQ0_REQ,
    output logic EXT_IRQ1_REQ,
    output logic SER0_RXD
);
    function automatic pmaf_mode_t mode_of(input logic [7:0] lo, input logic [7:0] hi,
                                           input int unsigned n);
        logic [15:0] both;
        both = {hi, lo};
        return pmaf_mode_t'(both[2*n +: 2]);
    endfunction

    function automatic logic [7:0] read_port(input logic [7:0] lat, input logic [7:0] pin,
                                             input logic [7:0] lo, input logic [7:0] hi);
        logic [7:0] r;
        r = lat;
        for (int unsigned i = 0; i < 8; i++) begin
            if (mode_of(lo, hi, i) == PMAF_MODE_INPUT) begin
                r[i] = pin[i];
            end
        end
        return r;
    endfunction

    logic [7:0] p1_lo_q, p1_lo_d, p1_hi_q, p1_hi_d, p1_lat_q, p1_lat_d;
    logic [7:0] p3_lo_q, p3_lo_d, p3_hi_q, p3_hi_d, p3_lat_q, p3_lat_d;
    logic [7:0] sel_q, sel_d, rdata_q, rdata_d;
    logic [7:0] p1_in_q, p3_in_q, p3_prev_q;
    logic [7:0] p3_alt, p3_val, p3_fall;
    logic [7:0] p1_out_c, p1_oe_c, p3_out_c, p3_oe_c;
    pmaf_pins_t p1_pins_q, p3_pins_q;
    logic tmr0_d, tmr0_q, tmr1_d, tmr1_q;
    logic irq0_d, irq0_q, irq1_d, irq1_q, rxd_d, rxd_q;
    logic shared_clk;

    // register file
    always_comb begin
        p1_lo_d = p1_lo_q;
        p1_hi_d = p1_hi_q;
        p1_lat_d = p1_lat_q;
        p3_lo_d = p3_lo_q;
        p3_hi_d = p3_hi_q;
        p3_lat_d = p3_lat_q;
        sel_d = sel_q;
        rdata_d = rdata_q;
        if (SFR_REQ.wr) begin
            if (SFR_REQ.addr == PMAF_ADDR_P1_MODE_LO) begin
                p1_lo_d = SFR_REQ.wdata; // RULE_01
            end else if (SFR_REQ.addr == PMAF_ADDR_P1_MODE_HI) begin
                p1_hi_d = SFR_REQ.wdata; // RULE_02
            end else if (SFR_REQ.addr == PMAF_ADDR_P1_LATCH) begin
                p1_lat_d = SFR_REQ.wdata; // RULE_14
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_LATCH) begin
                p3_lat_d = SFR_REQ.wdata; // RULE_04
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_MODE_LO) begin
                p3_lo_d = SFR_REQ.wdata; // RULE_13
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_MODE_HI) begin
                p3_hi_d = SFR_REQ.wdata; // RULE_13
            end else if (SFR_REQ.addr == PMAF_ADDR_PIN_SEL) begin
                sel_d = SFR_REQ.wdata & PMAF_PIN_SEL_MASK; // RULE_12
            end
        end
        if (SFR_REQ.rd) begin
            if (SFR_REQ.addr == PMAF_ADDR_P1_MODE_LO) begin
                rdata_d = p1_lo_q;
            end else if (SFR_REQ.addr == PMAF_ADDR_P1_MODE_HI) begin
                rdata_d = p1_hi_q;
            end else if (SFR_REQ.addr == PMAF_ADDR_P1_LATCH) begin
                rdata_d = read_port(p1_lat_q, p1_in_q, p1_lo_q, p1_hi_q); // RULE_14
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_LATCH) begin
                rdata_d = read_port(p3_lat_q, p3_in_q, p3_lo_q, p3_hi_q); // RULE_14
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_MODE_LO) begin
                rdata_d = p3_lo_q;
            end else if (SFR_REQ.addr == PMAF_ADDR_P3_MODE_HI) begin
                rdata_d = p3_hi_q;
            end else if (SFR_REQ.addr == PMAF_ADDR_PIN_SEL) begin
                rdata_d = sel_q;
            end else begin
                rdata_d = PMAF_RD_UNMAPPED;
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            p1_lo_q <= PMAF_RST_MODE;
            p1_hi_q <= PMAF_RST_MODE;
            p1_lat_q <= PMAF_RST_LATCH;
            p3_lo_q <= PMAF_RST_MODE;
            p3_hi_q <= PMAF_RST_MODE;
            p3_lat_q <= PMAF_RST_LATCH;
            sel_q <= PMAF_RST_PIN_SEL;
            rdata_q <= PMAF_RD_UNMAPPED;
        end else begin
            p1_lo_q <= p1_lo_d;
            p1_hi_q <= p1_hi_d;
            p1_lat_q <= p1_lat_d;
            p3_lo_q <= p3_lo_d;
            p3_hi_q <= p3_hi_d;
            p3_lat_q <= p3_lat_d;
            sel_q <= sel_d;
            rdata_q <= rdata_d;
        end
    end

    // alternate outputs idle high so that the latch alone sets the pin
    always_comb begin
        case (pmaf_clk_sel_t'(sel_q[1:0])) // RULE_12
            PMAF_CLK_SERIAL: shared_clk = SPI_SCK;
            PMAF_CLK_TWO_WIRE: shared_clk = TWI_SCL;
            PMAF_CLK_SOURCE: shared_clk = CLKS_OUT;
            default: shared_clk = 1'b1;
        endcase
        p3_alt = 8'hFF;
        if (SER0_ACTIVE) begin
            if (SER0_MODE == PMAF_SER_MODE0) begin
                p3_alt[PMAF_PIN_TXD] = SER0_SHIFT_CLK; // RULE_10
                p3_alt[PMAF_PIN_RXD] = SER0_M0_DRIVE ? SER0_M0_DOUT : 1'b1; // RULE_11
            end else begin
                p3_alt[PMAF_PIN_TXD] = SER0_TXD; // RULE_10
            end
        end
        if (CLK_SHARE_ACTIVE) begin
            p3_alt[PMAF_PIN_CLK] = shared_clk; // RULE_12
        end
        // a cleared latch bit holds the pin low and blocks the alternate output
        p3_val = p3_lat_q & p3_alt; // RULE_05
    end

    for (genvar g = 0; g < 8; g++) begin : g_cell
        pmaf_pin_cell u_p1 (
            .mode(mode_of(p1_lo_q, p1_hi_q, g)),
            .value(p1_lat_q[g]),
            .drv_out(p1_out_c[g]),
            .drv_oe(p1_oe_c[g])
        );
        pmaf_pin_cell u_p3 (
            .mode(mode_of(p3_lo_q, p3_hi_q, g)),
            .value(p3_val[g]),
            .drv_out(p3_out_c[g]),
            .drv_oe(p3_oe_c[g])
        );
    end

    // alternate inputs; pins sampled once, so edges lag the pad by one cycle
    always_comb begin
        p3_fall = p3_prev_q & ~p3_in_q;
        tmr1_d = p3_lat_q[PMAF_PIN_TMR1] & p3_fall[PMAF_PIN_TMR1]; // RULE_06 RULE_05
        tmr0_d = p3_lat_q[PMAF_PIN_TMR0] & p3_fall[PMAF_PIN_TMR0]; // RULE_07 RULE_05
        irq1_d = EXT_IRQ1_EN & p3_lat_q[PMAF_PIN_IRQ1] &
                 (EXT_IRQ1_EDGE ? p3_fall[PMAF_PIN_IRQ1] : ~p3_in_q[PMAF_PIN_IRQ1]); // RULE_08
        irq0_d = EXT_IRQ0_EN & p3_lat_q[PMAF_PIN_IRQ0] &
                 (EXT_IRQ0_EDGE ? p3_fall[PMAF_PIN_IRQ0] : ~p3_in_q[PMAF_PIN_IRQ0]); // RULE_09
        rxd_d = p3_lat_q[PMAF_PIN_RXD] ? p3_in_q[PMAF_PIN_RXD] : 1'b1; // RULE_11
    end

    always_ff @(posedge CLK_SYS or negedge RST_B) begin
        if (!RST_B) begin
            p1_in_q <= 8'hFF;
            p3_in_q <= 8'hFF;
            p3_prev_q <= 8'hFF;
            p1_pins_q <= '0;
            p3_pins_q <= '0;
            tmr0_q <= 1'b0;
            tmr1_q <= 1'b0;
            irq0_q <= 1'b0;
            irq1_q <= 1'b0;
            rxd_q <= 1'b1;
        end else begin
            p1_in_q <= P1_IN;
            p3_in_q <= P3_IN;
            p3_prev_q <= p3_in_q;
            p1_pins_q <= '{out: p1_out_c, oe: p1_oe_c};
            p3_pins_q <= '{out: p3_out_c, oe: p3_oe_c};
            tmr0_q <= tmr0_d;
            tmr1_q <= tmr1_d;
            irq0_q <= irq0_d;
            irq1_q <= irq1_d;
            rxd_q <= rxd_d;
        end
    end

    assign SFR_RDATA = rdata_q;
    assign P1_PINS = p1_pins_q;
    assign P3_PINS = p3_pins_q;
    assign TMR0_COUNT = tmr0_q;
    assign TMR1_COUNT = tmr1_q;
    assign EXT_IRQ0_REQ = irq0_q;
    assign EXT_IRQ1_REQ = irq1_q;
    assign SER0_RXD = rxd_q;

    a_mode_low_readback: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_01
        (SFR_REQ.wr && SFR_REQ.addr == PMAF_ADDR_P1_MODE_LO) ##1
        (SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == PMAF_ADDR_P1_MODE_LO)
        |=> SFR_RDATA == $past(SFR_REQ.wdata, 2))
        else $error("port one low mode readback wrong");
    a_mode_high_readback: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_02
        (SFR_REQ.wr && SFR_REQ.addr == PMAF_ADDR_P1_MODE_HI) ##1
        (SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == PMAF_ADDR_P1_MODE_HI)
        |=> SFR_RDATA == $past(SFR_REQ.wdata, 2))
        else $error("port one high mode readback wrong");
    a_push_pull_drive: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_03
        p1_lo_q[3:2] == PMAF_MODE_PUSH_PULL |=> P1_PINS.oe[1] && P1_PINS.out[1] == $past(p1_lat_q[1]))
        else $error("push-pull pin not driven from latch");
    a_open_drain_high: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_03
        p1_hi_q[3:2] == PMAF_MODE_OPEN_DRAIN && p1_lat_q[5] |=> !P1_PINS.oe[5])
        else $error("open-drain pin drives high");
    // checked on the clock: an edge of the enable itself would still see the old mode
    a_input_never_drives: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_03
        p3_hi_q[7:6] == PMAF_MODE_INPUT |=> !P3_PINS.oe[7])
        else $error("pin in input mode is driven");
    a_input_read_pin: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_14
        SFR_REQ.rd && SFR_REQ.addr == PMAF_ADDR_P3_LATCH && p3_lo_q[1:0] == PMAF_MODE_INPUT
        |=> SFR_RDATA[0] == $past(p3_in_q[0]))
        else $error("input pin read does not return pin level");
    a_alt_gated_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_05
        !p3_lat_q[PMAF_PIN_TMR0] |=> !TMR0_COUNT)
        else $error("timer zero counts with latch cleared");
    a_timer_one_count: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_06
        p3_lat_q[5] && $fell(p3_in_q[5]) |=> TMR1_COUNT ##1 !TMR1_COUNT || $fell(p3_in_q[5]))
        else $error("timer one count pulse wrong");
    a_timer_zero_count: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_07
        p3_lat_q[4] && p3_prev_q[4] && !p3_in_q[4] |=> TMR0_COUNT)
        else $error("timer zero falling edge missed");
    a_irq_one_level: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_08
        EXT_IRQ1_EN && !EXT_IRQ1_EDGE && p3_lat_q[3] && !p3_in_q[3] |=> EXT_IRQ1_REQ)
        else $error("external interrupt one level missed");
    a_irq_zero_masked: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_09
        !EXT_IRQ0_EN |=> !EXT_IRQ0_REQ)
        else $error("external interrupt zero raised while disabled");
    a_shared_clock_pin: assert property (@(posedge CLK_SYS) disable iff (!RST_B) // RULE_12
        CLK_SHARE_ACTIVE && sel_q[1:0] == PMAF_CLK_TWO_WIRE && p3_lat_q[6]
        |=> P3_PINS.out[6] == $past(TWI_SCL))
        else $error("shared clock pin source wrong");
endmodule
`default_nettype wire

// File: sim/pmaf_board.sv
`timescale 1ns/100ps
`default_nettype none
module pmaf_board
    import pmaf_pkg::*;
(
    input wire pmaf_pins_t pins,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_oe,
    output logic [7:0] level
);
    // a released line floats up on the board pull-up
    // limitation: contention is modelled as wired-and, so a driven high never wins against a low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = (pins.oe[i] ? pins.out[i] : 1'b1) & (ext_oe[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb
    import pmaf_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    pmaf_sfr_req_t req = '0;
    logic [7:0] rdata, p1_lvl, p3_lvl;
    pmaf_pins_t p1_pins, p3_pins;
    logic [7:0] ext1_v = 8'hFF, ext1_oe = 8'h00, ext3_v = 8'hFF, ext3_oe = 8'h3C;
    logic ser_act = 1'b0, txd = 1'b1, sclk = 1'b1, m0_dout = 1'b1, m0_drv = 1'b0;
    logic [1:0] ser_mode = 2'h1;
    logic clk_act = 1'b0, sck = 1'b1, scl = 1'b1, clks = 1'b1;
    logic irq0_en = 1'b1, irq1_en = 1'b1, irq0_edge = 1'b1, irq1_edge = 1'b1;
    logic [3:0] evs;
    logic rxd;
    int n_errors = 0;
    int num_checks = 0;

    always #10 clk = ~clk;

    pmaf_port pmaf_port_i (.CLK_SYS(clk), .RST_B(rst_b), .SFR_REQ(req), .SFR_RDATA(rdata),
        .P1_IN(p1_lvl), .P1_PINS(p1_pins), .P3_IN(p3_lvl), .P3_PINS(p3_pins),
        .SER0_ACTIVE(ser_act), .SER0_MODE(ser_mode), .SER0_TXD(txd), .SER0_SHIFT_CLK(sclk),
        .SER0_M0_DOUT(m0_dout), .SER0_M0_DRIVE(m0_drv), .CLK_SHARE_ACTIVE(clk_act),
        .SPI_SCK(sck), .TWI_SCL(scl), .CLKS_OUT(clks), .EXT_IRQ0_EN(irq0_en),
        .EXT_IRQ1_EN(irq1_en), .EXT_IRQ0_EDGE(irq0_edge), .EXT_IRQ1_EDGE(irq1_edge),
        .TMR0_COUNT(evs[0]), .TMR1_COUNT(evs[1]), .EXT_IRQ0_REQ(evs[2]),
        .EXT_IRQ1_REQ(evs[3]), .SER0_RXD(rxd));
    pmaf_board pmaf_board_p1_i (.pins(p1_pins), .ext_val(ext1_v), .ext_oe(ext1_oe), .level(p1_lvl));
    pmaf_board pmaf_board_p3_i (.pins(p3_pins), .ext_val(ext3_v), .ext_oe(ext3_oe), .level(p3_lvl));

    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        req.wr = 1'b0;
        req.rd = 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // strobe stays up until tick drops it or the next request replaces it,
    // so back-to-back requests never drop and raise it in one time step
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        #1;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        #1;
        chk("read data", rdata, exp);
    endtask

    function automatic logic [7:0] exp_oe(input logic [15:0] m, input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = (m[2*i+:2] == 2'b11) ? 1'b0 : (m[2*i+:2] == 2'b01) ? 1'b1 : ~v[i];
        end
        return r;
    endfunction

    task automatic t_reset();
        rchk(PMAF_ADDR_P1_MODE_LO, 8'h00);
        rchk(PMAF_ADDR_P1_MODE_HI, 8'h00);
        rchk(PMAF_ADDR_P3_LATCH, 8'hFF);
        rchk(PMAF_ADDR_P3_MODE_LO, 8'h00);
        rchk(PMAF_ADDR_P3_MODE_HI, 8'h00);
        rchk(8'hA0, PMAF_RD_UNMAPPED);
        chk("p3 oe after reset", p3_pins.oe, 8'h00);
    endtask

    // every code appears in both registers, and each latch pattern flips the drive
    task automatic t_modes();
        logic [7:0] pat [3] = '{8'h00, 8'hFF, 8'h5A};
        logic [7:0] e;
        wr(PMAF_ADDR_P1_MODE_LO, 8'hE4);
        rchk(PMAF_ADDR_P1_MODE_LO, 8'hE4);
        wr(PMAF_ADDR_P1_MODE_HI, 8'h1B);
        rchk(PMAF_ADDR_P1_MODE_HI, 8'h1B);
        wr(PMAF_ADDR_P3_MODE_LO, 8'h1B);
        wr(PMAF_ADDR_P3_MODE_HI, 8'hE4);
        for (int k = 0; k < 3; k++) begin
            wr(PMAF_ADDR_P1_LATCH, pat[k]);
            wr(PMAF_ADDR_P3_LATCH, pat[k]);
            tick(3);
            e = exp_oe(16'h1BE4, pat[k]);
            chk("p1 oe", p1_pins.oe, e);
            chk("p1 out", p1_pins.out & e, pat[k] & e);
            chk("p3 oe", p3_pins.oe, exp_oe(16'hE41B, pat[k]));
        end
        // pins 0 and 7 are input only and float high, so they read as ones
        rchk(PMAF_ADDR_P3_LATCH, 8'hDB);
    endtask

    task automatic t_readback();
        ext1_v = 8'hA5;
        ext1_oe = 8'hFF;
        wr(PMAF_ADDR_P1_MODE_LO, 8'h00);
        wr(PMAF_ADDR_P1_MODE_HI, 8'h00);
        wr(PMAF_ADDR_P1_LATCH, 8'h3C);
        tick(3);
        rchk(PMAF_ADDR_P1_LATCH, 8'h3C);
        wr(PMAF_ADDR_P1_MODE_LO, 8'hFF);
        wr(PMAF_ADDR_P1_MODE_HI, 8'hFF);
        tick(3);
        rchk(PMAF_ADDR_P1_LATCH, 8'hA5);
        ext1_oe = 8'h00;
    endtask

    // one falling edge on a pin, held low for six cycles, high outputs counted
    task automatic pulse(input int pin, input int ev, input logic lb, input int exp);
        logic [7:0] n;
        n = 8'h00;
        wr(PMAF_ADDR_P3_LATCH, lb ? 8'hFF : ~(8'h01 << pin));
        tick(3);
        ext3_v[pin] = 1'b0;
        for (int i = 0; i < 6; i++) begin
            tick(1);
            n = n + {7'h00, evs[ev]};
        end
        ext3_v[pin] = 1'b1;
        tick(4);
        chk("event count", n, exp[7:0]);
    endtask

    task automatic t_events();
        wr(PMAF_ADDR_P3_MODE_LO, 8'h00);
        wr(PMAF_ADDR_P3_MODE_HI, 8'h00);
        pulse(5, 1, 1'b1, 1);
        pulse(5, 1, 1'b0, 0);
        pulse(4, 0, 1'b0, 0);
        pulse(4, 0, 1'b1, 1);
        pulse(3, 3, 1'b1, 1);
        pulse(2, 2, 1'b1, 1);
        irq0_en = 1'b0;
        pulse(2, 2, 1'b1, 0);
        irq0_en = 1'b1;
        irq0_edge = 1'b0;
        pulse(2, 2, 1'b1, 5);
        irq1_edge = 1'b0;
        pulse(3, 3, 1'b1, 5);
        pulse(3, 3, 1'b0, 0);
    endtask

    task automatic t_serial();
        wr(PMAF_ADDR_P3_LATCH, 8'hFF);
        ser_act = 1'b1;
        txd = 1'b0;
        tick(3);
        chk("transmit pin", p3_lvl[1], 8'h00);
        ser_mode = PMAF_SER_MODE0;
        sclk = 1'b0;
        tick(3);
        chk("shift clock pin", p3_lvl[1], 8'h00);
        sclk = 1'b1;
        tick(3);
        chk("shift clock pin", p3_lvl[1], 8'h01);
        m0_drv = 1'b1;
        m0_dout = 1'b0;
        tick(3);
        chk("mode0 data pin", p3_lvl[0], 8'h00);
        m0_drv = 1'b0;
        ser_mode = 2'h2;
        ext3_oe[0] = 1'b1;
        ext3_v[0] = 1'b0;
        tick(3);
        chk("receive data", rxd, 8'h00);
        wr(PMAF_ADDR_P3_LATCH, 8'hFE);
        tick(3);
        chk("receive blocked", rxd, 8'h01);
        ext3_v[0] = 1'b1;
        ser_act = 1'b0;
    endtask

    task automatic t_clock();
        wr(PMAF_ADDR_P3_LATCH, 8'hFF);
        wr(PMAF_ADDR_PIN_SEL, 8'hFF);
        rchk(PMAF_ADDR_PIN_SEL, PMAF_PIN_SEL_MASK);
        clk_act = 1'b1;
        for (int s = 0; s < 4; s++) begin
            wr(PMAF_ADDR_PIN_SEL, s[7:0]);
            for (int v = 0; v < 2; v++) begin
                {clks, scl, sck} = (v == 1) ? (3'b001 << s) : ~(3'b001 << s);
                tick(3);
                chk("shared clock pin", p3_lvl[6], (s == 3) ? 8'h01 : v[7:0]);
            end
        end
        clk_act = 1'b0;
    endtask

    initial begin
        #1000000;
        n_errors++;
        end_sim();
    end

    initial begin
        tick(16);
        rst_b = 1'b1;
        t_reset();
        t_modes();
        t_readback();
        t_events();
        t_serial();
        t_clock();
        end_sim();
    end
endmodule
`default_nettype wire
